// >>> core/pcsr_defs.vh
// Constants for the port control and status register bank.
// Assumes byte addresses on an 8-bit register address port.
`ifndef PCSR_DEFS_VH
`define PCSR_DEFS_VH

// ==========================================================
// Register byte offsets
`define PCSR_OFS_INT_STATUS 8'hE0
`define PCSR_OFS_INT_MASK 8'hE2
`define PCSR_OFS_MIR_BASIC_CTRL 8'hE4
`define PCSR_OFS_MIR_BASIC_STAT 8'hE6
`define PCSR_OFS_MIR_ADVERT 8'hEC
`define PCSR_OFS_MIR_PARTNER 8'hEE
`define PCSR_OFS_PORT_CONTROL 8'hF6
`define PCSR_OFS_PORT_STATUS 8'hF8
`define PCSR_OFS_RSVD_FIRST 8'hFA
`define PCSR_OFS_RSVD_LAST 8'hFF

// ==========================================================
// Port control field positions
`define PCSR_CTL_LED_OFF 15
`define PCSR_CTL_TX_DIS 14
`define PCSR_CTL_AN_RESTART 13
`define PCSR_CTL_MDIX_DIS 10
`define PCSR_CTL_FORCE_MDIX 9
`define PCSR_CTL_AN_EN 7
`define PCSR_CTL_SPEED 6
`define PCSR_CTL_DUPLEX 5
`define PCSR_CTL_ADV_HI 4
`define PCSR_CTL_ADV_LO 0

// ==========================================================
// Port status field positions
`define PCSR_STA_ALGO 15
`define PCSR_STA_POLARITY 13
`define PCSR_STA_SPEED 10
`define PCSR_STA_DUPLEX 9
`define PCSR_STA_STRAIGHT 7
`define PCSR_STA_AN_DONE 6
`define PCSR_STA_LINK 5

// ==========================================================
// Mirrored basic control field positions
`define PCSR_MBC_LED_OFF 0
`define PCSR_MBC_TX_DIS 1
`define PCSR_MBC_MDIX_DIS 3
`define PCSR_MBC_FORCE_MDIX 4
`define PCSR_MBC_ALGO 5
`define PCSR_MBC_DUPLEX 8
`define PCSR_MBC_AN_RESTART 9
`define PCSR_MBC_AN_EN 12
`define PCSR_MBC_SPEED 13

// Mirrored basic status field positions
`define PCSR_MBS_LINK 2
`define PCSR_MBS_AN_DONE 5

// Ability positions in the mirrored advertisement and partner views
`define PCSR_ABL_PAUSE 10
`define PCSR_ABL_100F 8
`define PCSR_ABL_100H 7
`define PCSR_ABL_10F 6
`define PCSR_ABL_10H 5
`define PCSR_ABL_SEL_HI 4

// ==========================================================
// Reset values
`define PCSR_CTL_RESET 16'h00FF
`define PCSR_ALGO_RESET 1'b1
`define PCSR_SELECTOR 5'h01
`define PCSR_MASK_RESET 3'h0

// Interrupt event positions
`define PCSR_EV_LINK 0
`define PCSR_EV_AN_DONE 1
`define PCSR_EV_POLARITY 2

`endif

// >>> core/pcsr_regs.v
// Port control and status register bank for the single Ethernet port.
// Assumes one clock, synchronous status inputs from the PHY machinery,
// and a master that keeps strobes one cycle long and never overlapping.
// Reserved control bits 12, 11 and 8 are kept as plain storage.
`include "pcsr_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module pcsr_regs #(
   parameter ADDR_W = 8,
   parameter DATA_W = 16,
   parameter NUM_IND = 4,
   parameter NUM_EV = 3
) (
   input wire core_clk_i,
   input wire resetn_i,
   // Register port
   input wire [ADDR_W-1:0] reg_addr_i,
   input wire [DATA_W-1:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   output wire [DATA_W-1:0] reg_rdata_o,
   // Indicator drive
   input wire [NUM_IND-1:0] indicator_normal_i,
   output wire port_indicator_3_o,
   output wire port_indicator_2_o,
   output wire port_indicator_1_o,
   output wire port_indicator_0_o,
   // Controls towards the PHY machinery
   output wire tx_disable_o,
   output wire an_restart_o,
   output wire an_enable_o,
   output wire force_speed_100_o,
   output wire force_duplex_full_o,
   output wire mdix_auto_disable_o,
   output wire force_crossed_o,
   output wire crossover_algorithm_select_o,
   output wire [4:0] advertise_o,
   // State from the PHY machinery
   input wire polarity_reversed_i,
   input wire speed_100_i,
   input wire duplex_full_i,
   input wire wiring_straight_i,
   input wire an_done_i,
   input wire link_good_i,
   input wire [4:0] partner_ability_i,
   // Interrupt
   output wire irq_o
);

   // ==========================================================
   // Storage
   reg [DATA_W-1:0] port_control_reg;
   reg [DATA_W-1:0] port_control_next;
   reg algo_reg;
   reg algo_next;
   // Restart pulse is kept apart from the stored bit, which only reads back
   reg an_restart_reg;
   reg an_restart_next;
   // Registered read data; the bus sees it in the cycle after the strobe
   reg [DATA_W-1:0] rdata_reg;
   reg [DATA_W-1:0] rdata_next;
   // Interrupt state: sticky events, enables and last seen input levels
   reg [NUM_EV-1:0] int_status_reg;
   reg [NUM_EV-1:0] int_status_next;
   reg [NUM_EV-1:0] int_mask_reg;
   reg [NUM_EV-1:0] int_mask_next;
   reg [NUM_EV-1:0] ev_prev_reg;

   wire wr_ctl;
   wire wr_sta;
   wire wr_mbc;
   wire wr_adv;
   wire wr_ist;
   wire wr_msk;
   wire rsv_hit;
   reg [DATA_W-1:0] status_view;
   wire [DATA_W-1:0] mbc_view;
   reg [DATA_W-1:0] mbs_view;
   reg [DATA_W-1:0] adv_view;
   reg [DATA_W-1:0] lpa_view;
   wire [NUM_EV-1:0] ev_now;
   wire [NUM_EV-1:0] ev_hit;
   wire [NUM_EV-1:0] ev_clr;

   // ==========================================================
   // Write decode
   assign wr_ctl = reg_wr_i && (reg_addr_i == `PCSR_OFS_PORT_CONTROL);
   assign wr_sta = reg_wr_i && (reg_addr_i == `PCSR_OFS_PORT_STATUS);
   assign wr_mbc = reg_wr_i && (reg_addr_i == `PCSR_OFS_MIR_BASIC_CTRL);
   assign wr_adv = reg_wr_i && (reg_addr_i == `PCSR_OFS_MIR_ADVERT);
   assign wr_ist = reg_wr_i && (reg_addr_i == `PCSR_OFS_INT_STATUS);
   assign wr_msk = reg_wr_i && (reg_addr_i == `PCSR_OFS_INT_MASK);

   // Map of the bank, by byte offset:
   //   E0 interrupt status, write one to clear
   //   E2 interrupt mask
   //   E4 mirrored basic control, E6 mirrored basic status
   //   EC mirrored advertisement, EE mirrored partner ability
   //   F6 port control, F8 port status
   //   FA up to the top of the map is reserved
   // Only exact matches are decoded, so odd offsets and the reserved tail
   // can never disturb stored state.
   // The reserved tail runs to the last byte of the 8-bit map
   assign rsv_hit = (reg_addr_i >= `PCSR_OFS_RSVD_FIRST);

   // ==========================================================
   // Control storage next state
   // Both views land in one register, so neither view can go stale.
   always @* begin
      port_control_next = port_control_reg;
      algo_next = algo_reg;
      an_restart_next = 1'b0;
      // One address per strobe, so at most one of these blocks applies
      if (wr_ctl) begin
         port_control_next = reg_wdata_i;
         an_restart_next = reg_wdata_i[`PCSR_CTL_AN_RESTART];
      end
      if (wr_sta) begin
         // Only the algorithm bit of the status word is writable
         algo_next = reg_wdata_i[`PCSR_STA_ALGO];
      end
      // Mirrored basic control: shared bits land in the one word, except the algorithm bit, which goes to algo_reg
      if (wr_mbc) begin
         port_control_next[`PCSR_CTL_LED_OFF] =
            reg_wdata_i[`PCSR_MBC_LED_OFF];
         port_control_next[`PCSR_CTL_TX_DIS] =
            reg_wdata_i[`PCSR_MBC_TX_DIS];
         port_control_next[`PCSR_CTL_AN_RESTART] =
            reg_wdata_i[`PCSR_MBC_AN_RESTART];
         port_control_next[`PCSR_CTL_MDIX_DIS] =
            reg_wdata_i[`PCSR_MBC_MDIX_DIS];
         port_control_next[`PCSR_CTL_FORCE_MDIX] =
            reg_wdata_i[`PCSR_MBC_FORCE_MDIX];
         port_control_next[`PCSR_CTL_AN_EN] =
            reg_wdata_i[`PCSR_MBC_AN_EN];
         port_control_next[`PCSR_CTL_SPEED] =
            reg_wdata_i[`PCSR_MBC_SPEED];
         port_control_next[`PCSR_CTL_DUPLEX] =
            reg_wdata_i[`PCSR_MBC_DUPLEX];
         algo_next = reg_wdata_i[`PCSR_MBC_ALGO];
         an_restart_next = reg_wdata_i[`PCSR_MBC_AN_RESTART];
      end
      // Mirrored advertisement: selector and reserved bits are dropped
      if (wr_adv) begin
         port_control_next[4] = reg_wdata_i[`PCSR_ABL_PAUSE];
         port_control_next[3] = reg_wdata_i[`PCSR_ABL_100F];
         port_control_next[2] = reg_wdata_i[`PCSR_ABL_100H];
         port_control_next[1] = reg_wdata_i[`PCSR_ABL_10F];
         port_control_next[0] = reg_wdata_i[`PCSR_ABL_10H];
      end
   end

   // Control registers; reset gives negotiation on, all abilities offered
   // Synchronous reset only; every register here is a plain flop
   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         port_control_reg <= `PCSR_CTL_RESET;
         algo_reg <= `PCSR_ALGO_RESET;
         an_restart_reg <= 1'b0;
      end else begin
         port_control_reg <= port_control_next;
         algo_reg <= algo_next;
         an_restart_reg <= an_restart_next;
      end
   end

   // ==========================================================
   // Indicator drive: high turns an indicator off
   // The blanking bit overrides the normal activity levels, so software
   // can darken the port without touching the activity logic
   genvar gi;
   wire [NUM_IND-1:0] ind_drive;
   generate
      for (gi = 0; gi < NUM_IND; gi = gi + 1) begin : g_ind
         assign ind_drive[gi] = port_control_reg[`PCSR_CTL_LED_OFF] |
            indicator_normal_i[gi];
      end
   endgenerate
   assign port_indicator_3_o = ind_drive[3];
   assign port_indicator_2_o = ind_drive[2];
   assign port_indicator_1_o = ind_drive[1];
   assign port_indicator_0_o = ind_drive[0];

   // ==========================================================
   // Controls towards the PHY machinery
   assign tx_disable_o = port_control_reg[`PCSR_CTL_TX_DIS];
   // One-cycle pulse per write of one; the stored bit only reads back
   assign an_restart_o = an_restart_reg;
   assign an_enable_o = port_control_reg[`PCSR_CTL_AN_EN];
   assign force_speed_100_o = port_control_reg[`PCSR_CTL_SPEED];
   // Also consulted by the PHY when negotiation fails
   assign force_duplex_full_o =
      port_control_reg[`PCSR_CTL_DUPLEX];
   assign mdix_auto_disable_o =
      port_control_reg[`PCSR_CTL_MDIX_DIS];
   // Force only takes effect while automatic detection is off
   assign force_crossed_o = port_control_reg[`PCSR_CTL_MDIX_DIS] &
      port_control_reg[`PCSR_CTL_FORCE_MDIX];
   assign crossover_algorithm_select_o = algo_reg;
   assign advertise_o = port_control_reg[`PCSR_CTL_ADV_HI:`PCSR_CTL_ADV_LO];
   // (above)

   // ==========================================================
   // Read views
   // Status word: read-only fields come straight from the PHY side,
   // so a write to this offset can only reach the algorithm bit
   always @* begin
      status_view = {DATA_W{1'b0}};
      status_view[`PCSR_STA_ALGO] = algo_reg;
      status_view[`PCSR_STA_POLARITY] = polarity_reversed_i;
      status_view[`PCSR_STA_SPEED] = speed_100_i;
      status_view[`PCSR_STA_DUPLEX] = duplex_full_i;
      status_view[`PCSR_STA_STRAIGHT] = wiring_straight_i;
      status_view[`PCSR_STA_AN_DONE] = an_done_i;
      status_view[`PCSR_STA_LINK] = link_good_i;
      status_view[4:0] = partner_ability_i;
   end

   // Mirrored basic control: only the shared bits read back
   // Restart reads back as last written; the pulse is separate
   assign mbc_view = {2'b00,
      port_control_reg[`PCSR_CTL_SPEED],
      port_control_reg[`PCSR_CTL_AN_EN],
      2'b00,
      port_control_reg[`PCSR_CTL_AN_RESTART],
      port_control_reg[`PCSR_CTL_DUPLEX],
      2'b00,
      algo_reg,
      port_control_reg[`PCSR_CTL_FORCE_MDIX],
      port_control_reg[`PCSR_CTL_MDIX_DIS],
      1'b0,
      port_control_reg[`PCSR_CTL_TX_DIS],
      port_control_reg[`PCSR_CTL_LED_OFF]};

   // Mirrored basic status: the same live levels as the port status word
   always @* begin
      mbs_view = {DATA_W{1'b0}};
      mbs_view[`PCSR_MBS_AN_DONE] = an_done_i;
      mbs_view[`PCSR_MBS_LINK] = link_good_i;
   end

   // Advertisement view: abilities sit at their standard positions and
   // the selector field is a constant, so writes cannot change it
   always @* begin
      adv_view = {DATA_W{1'b0}};
      adv_view[`PCSR_ABL_PAUSE] = port_control_reg[4];
      adv_view[`PCSR_ABL_100F] = port_control_reg[3];
      adv_view[`PCSR_ABL_100H] = port_control_reg[2];
      adv_view[`PCSR_ABL_10F] = port_control_reg[1];
      adv_view[`PCSR_ABL_10H] = port_control_reg[0];
      adv_view[`PCSR_ABL_SEL_HI:0] = `PCSR_SELECTOR;
   end

   // Partner view uses the same layout; its low field reads the constant
   always @* begin
      lpa_view = {DATA_W{1'b0}};
      lpa_view[`PCSR_ABL_PAUSE] = partner_ability_i[4];
      lpa_view[`PCSR_ABL_100F] = partner_ability_i[3];
      lpa_view[`PCSR_ABL_100H] = partner_ability_i[2];
      lpa_view[`PCSR_ABL_10F] = partner_ability_i[1];
      lpa_view[`PCSR_ABL_10H] = partner_ability_i[0];
      lpa_view[`PCSR_ABL_SEL_HI:0] = `PCSR_SELECTOR;
   end

   // ==========================================================
   // Read mux; reserved and unmapped addresses read zero
   // Zero outside the read cycle keeps the data port quiet on idle cycles
   always @* begin
      rdata_next = {DATA_W{1'b0}};
      if (reg_rd_i && !rsv_hit) begin
         case (reg_addr_i)
            `PCSR_OFS_PORT_CONTROL: rdata_next = port_control_reg;
            `PCSR_OFS_PORT_STATUS: rdata_next = status_view;
            `PCSR_OFS_MIR_BASIC_CTRL: rdata_next = mbc_view;
            `PCSR_OFS_MIR_BASIC_STAT: rdata_next = mbs_view;
            `PCSR_OFS_MIR_ADVERT: rdata_next = adv_view;
            `PCSR_OFS_MIR_PARTNER: rdata_next = lpa_view;
            `PCSR_OFS_INT_STATUS:
               rdata_next = {{(DATA_W-NUM_EV){1'b0}}, int_status_reg};
            `PCSR_OFS_INT_MASK:
               rdata_next = {{(DATA_W-NUM_EV){1'b0}}, int_mask_reg};
            default: rdata_next = {DATA_W{1'b0}};
         endcase
      end
   end

   // Read data stands only in the cycle after the read strobe
   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         rdata_reg <= 16'h0000;
      end else begin
         rdata_reg <= rdata_next;
      end
   end
   assign reg_rdata_o = rdata_reg;

   // ==========================================================
   // Interrupt events: link change, negotiation done, polarity change
   // Event order matches the interrupt status bit positions
   assign ev_now = {polarity_reversed_i, an_done_i, link_good_i};
   // Write-one-to-clear: only a write to the status offset clears
   assign ev_clr = wr_ist ? reg_wdata_i[NUM_EV-1:0] : {NUM_EV{1'b0}};

   // Edge detection per event bit
   generate
      for (gi = 0; gi < NUM_EV; gi = gi + 1) begin : g_ev
         // Negotiation counts on rising edge only, others on any change
         if (gi == `PCSR_EV_AN_DONE) begin : g_rise
            assign ev_hit[gi] = ev_now[gi] & ~ev_prev_reg[gi];
         end else begin : g_chg
            assign ev_hit[gi] = ev_now[gi] ^ ev_prev_reg[gi];
         end
      end
   endgenerate

   // Sticky next state; a set in the clearing cycle wins, so software
   // can never wipe out an event that it has not yet seen
   always @* begin
      int_status_next = ev_hit | (int_status_reg & ~ev_clr);
   end

   // Sticky bits and last levels share one process, one driver per bit.
   // Last levels reset low: an input already high at release is an event.
   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         int_status_reg <= {NUM_EV{1'b0}};
         ev_prev_reg <= {NUM_EV{1'b0}};
      end else begin
         int_status_reg <= int_status_next;
         ev_prev_reg <= ev_now;
      end
   end

   // Mask register
   // Resets to all zero, so nothing interrupts before software opts in
   always @* begin
      int_mask_next = int_mask_reg;
      if (wr_msk) begin
         int_mask_next = reg_wdata_i[NUM_EV-1:0];
      end
   end

   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         int_mask_reg <= `PCSR_MASK_RESET;
      end else begin
         int_mask_reg <= int_mask_next;
      end
   end

   // Level interrupt while any enabled sticky bit is set
   // Drops in the cycle after the clearing write, as the bits are flops
   assign irq_o = |(int_status_reg & int_mask_reg);

endmodule // pcsr_regs

`default_nettype wire

// >>> sim/pcsr_link_partner.sv
// Behavioural far side: PHY machinery plus the cable link partner.
// Assumes the bank's control outputs and one shared clock.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Link partner model
module pcsr_link_partner #(
   parameter logic [4:0] PART_ABL = 5'h1B
) (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic link_up_i,
   input wire logic crossed_i,
   input wire logic pol_i,
   input wire logic an_en_i,
   input wire logic restart_i,
   input wire logic spd_i,
   input wire logic dup_i,
   input wire logic tx_dis_i,
   input wire logic [4:0] adv_i,
   output logic pol_o,
   output logic spd_o,
   output logic dup_o,
   output logic straight_o,
   output logic done_o,
   output logic link_o,
   output logic [4:0] abl_o
);
   logic [1:0] cnt;
   logic fast, full;
   // Negotiation takes four cycles; a restart or lost link starts over
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i || restart_i || !link_o || !an_en_i) begin
         cnt <= 2'h0;
         done_o <= 1'b0;
      end else if (cnt != 2'h3) begin
         cnt <= cnt + 2'h1;
      end else begin
         done_o <= 1'b1;
      end
   end
   // Highest common ability wins; a failed negotiation falls back
   assign fast = |(adv_i[3:2] & PART_ABL[3:2]);
   assign full = (adv_i[3] & PART_ABL[3]) | (~fast & adv_i[1] & PART_ABL[1]);
   assign spd_o = an_en_i ? done_o & fast : spd_i;
   assign dup_o = (an_en_i & done_o) ? full : dup_i;
   assign link_o = link_up_i & ~tx_dis_i;
   assign pol_o = pol_i & link_o;
   assign straight_o = ~crossed_i;
   assign abl_o = done_o ? PART_ABL : 5'h00;
endmodule // pcsr_link_partner
`default_nettype wire

// >>> sim/pcsr_regs_assertions.sv
// Port-level checker for the control and status bank.
// Assumes it is bound into pcsr_regs with default widths.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Checker
module pcsr_regs_chk (
   input wire core_clk_i,
   input wire resetn_i,
   input wire [7:0] reg_addr_i,
   input wire [15:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   input wire [15:0] reg_rdata_o,
   input wire port_indicator_3_o,
   input wire port_indicator_2_o,
   input wire port_indicator_1_o,
   input wire port_indicator_0_o,
   input wire tx_disable_o,
   input wire an_restart_o,
   input wire an_enable_o,
   input wire force_speed_100_o,
   input wire force_duplex_full_o,
   input wire mdix_auto_disable_o,
   input wire force_crossed_o,
   input wire crossover_algorithm_select_o,
   input wire [4:0] advertise_o,
   input wire polarity_reversed_i,
   input wire speed_100_i,
   input wire duplex_full_i,
   input wire wiring_straight_i,
   input wire an_done_i,
   input wire link_good_i,
   input wire [4:0] partner_ability_i
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);
   wire ctl_wr = reg_wr_i && reg_addr_i == 8'hF6;
   // Status word as it should read, taken at the read edge
   wire [15:0] sta = {crossover_algorithm_select_o, 1'b0,
      polarity_reversed_i, 2'b00, speed_100_i, duplex_full_i, 1'b0,
      wiring_straight_i, an_done_i, link_good_i, partner_ability_i};
   property p_led; ctl_wr && reg_wdata_i[15] |=> {port_indicator_3_o,
      port_indicator_2_o, port_indicator_1_o, port_indicator_0_o} == 4'hF;
   endproperty
   a_led: assert property (p_led) else $error("led off");
   property p_tx; ctl_wr |=> tx_disable_o == $past(reg_wdata_i[14]);
   endproperty
   a_tx: assert property (p_tx) else $error("tx dis");
   property p_rst; ctl_wr && reg_wdata_i[13] |=> an_restart_o; endproperty
   a_rst: assert property (p_rst) else $error("restart");
   property p_pls; an_restart_o |-> $past(reg_wr_i); endproperty
   a_pls: assert property (p_pls) else $error("pulse");
   property p_mdx; ctl_wr |=> mdix_auto_disable_o == $past(reg_wdata_i[10]);
   endproperty
   a_mdx: assert property (p_mdx) else $error("mdix");
   property p_fcr; force_crossed_o |-> mdix_auto_disable_o; endproperty
   a_fcr: assert property (p_fcr) else $error("crossed");
   property p_mode; ctl_wr |=> {an_enable_o, force_speed_100_o,
      force_duplex_full_o, advertise_o} == $past(reg_wdata_i[7:0]);
   endproperty
   a_mode: assert property (p_mode) else $error("mode");
   property p_sta; reg_rd_i && reg_addr_i == 8'hF8 |=>
      reg_rdata_o == $past(sta); endproperty
   a_sta: assert property (p_sta) else $error("status");
   property p_rsv; reg_rd_i && reg_addr_i >= 8'hFA |=>
      reg_rdata_o == 16'h0000; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved");
endmodule // pcsr_regs_chk
bind pcsr_regs pcsr_regs_chk i_chk (.core_clk_i(core_clk_i),
   .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
   .port_indicator_3_o(port_indicator_3_o),
   .port_indicator_2_o(port_indicator_2_o),
   .port_indicator_1_o(port_indicator_1_o),
   .port_indicator_0_o(port_indicator_0_o), .tx_disable_o(tx_disable_o),
   .an_restart_o(an_restart_o), .an_enable_o(an_enable_o),
   .force_speed_100_o(force_speed_100_o),
   .force_duplex_full_o(force_duplex_full_o),
   .mdix_auto_disable_o(mdix_auto_disable_o),
   .force_crossed_o(force_crossed_o),
   .crossover_algorithm_select_o(crossover_algorithm_select_o),
   .advertise_o(advertise_o), .polarity_reversed_i(polarity_reversed_i),
   .speed_100_i(speed_100_i), .duplex_full_i(duplex_full_i),
   .wiring_straight_i(wiring_straight_i), .an_done_i(an_done_i),
   .link_good_i(link_good_i), .partner_ability_i(partner_ability_i));
`default_nettype wire

// >>> sim/pcsr_regs_bench.sv
// Self-checking bench for the port control and status bank.
// Assumes pcsr_regs, its bound checker and the link partner model.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bench top
module pcsr_regs_bench;
   logic clk, resetn, wr, rd, link_up, pol, txd, rst, ane, spd, dup;
   logic mdx, fcr, alg, irq, s_pol, s_spd, s_dup, s_str, s_done, s_link;
   logic [7:0] addr;
   logic [15:0] wdata, rdata;
   logic [3:0] ind_n;
   wire [3:0] ind;
   logic [4:0] adv, s_abl;
   int err_total, samples_checked;
   pcsr_regs i_pcsr_regs (.core_clk_i(clk), .resetn_i(resetn),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_rdata_o(rdata), .indicator_normal_i(ind_n),
      .port_indicator_3_o(ind[3]), .port_indicator_2_o(ind[2]),
      .port_indicator_1_o(ind[1]), .port_indicator_0_o(ind[0]),
      .tx_disable_o(txd), .an_restart_o(rst), .an_enable_o(ane),
      .force_speed_100_o(spd), .force_duplex_full_o(dup),
      .mdix_auto_disable_o(mdx), .force_crossed_o(fcr),
      .crossover_algorithm_select_o(alg), .advertise_o(adv),
      .polarity_reversed_i(s_pol), .speed_100_i(s_spd),
      .duplex_full_i(s_dup), .wiring_straight_i(s_str), .an_done_i(s_done),
      .link_good_i(s_link), .partner_ability_i(s_abl), .irq_o(irq));
   pcsr_link_partner i_pcsr_link_partner (.core_clk_i(clk),
      .resetn_i(resetn), .link_up_i(link_up), .crossed_i(1'b0),
      .pol_i(pol), .an_en_i(ane), .restart_i(rst), .spd_i(spd),
      .dup_i(dup), .tx_dis_i(txd), .adv_i(adv), .pol_o(s_pol),
      .spd_o(s_spd), .dup_o(s_dup), .straight_o(s_str), .done_o(s_done),
      .link_o(s_link), .abl_o(s_abl));
   // Free-running 40 ns clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [15:0] s, e);
      samples_checked++;
      if (s !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   // One-cycle strobes; outputs are looked at once the edge has landed
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a; wdata <= d; wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
      @(posedge clk);
      addr <= a; rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk("rdata", rdata, e);
   endtask
   task automatic print_verdict;
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_reset;
      rd_reg(8'hF6, 16'h00FF);
      rd_reg(8'hF8, 16'h8280);
      chk("ind", ind, 4'h5);
   endtask
   task automatic t_ctl;
      wr_reg(8'hF6, 16'hC600);
      chk("ind", ind, 4'hF);
      chk("ctl", {txd, mdx, fcr, ane, adv}, 9'h1C0);
      wr_reg(8'hF6, 16'h0200);
      chk("ctl", {ind, txd, fcr}, 6'h14);
      chk("mode", {ane, spd, dup}, 3'h0);
   endtask
   // Restart, negotiation and the interrupt path with link coming up
   task automatic t_link;
      int i;
      wr_reg(8'hE2, 16'h0001);
      wr_reg(8'hF6, 16'h20FF);
      chk("restart", rst, 1'b1);
      @(posedge clk);
      #1;
      chk("restart", rst, 1'b0);
      link_up <= 1'b1;
      for (i = 0; i < 50 && s_done !== 1'b1; i++) @(posedge clk);
      if (s_done !== 1'b1) begin
         err_total++;
         print_verdict();
      end
      rd_reg(8'hF8, 16'h86FB);
      chk("irq", irq, 1'b1);
      rd_reg(8'hE0, 16'h0003);
      wr_reg(8'hE0, 16'h0001);
      chk("irq", irq, 1'b0);
      pol <= 1'b1;
      rd_reg(8'hE0, 16'h0006);
      chk("irq", irq, 1'b0);
      rd_reg(8'hF8, 16'hA6FB);
   endtask
   // Mirrored view, forced half duplex, read-only bits and reserved space
   task automatic t_mirror;
      wr_reg(8'hE4, 16'h2000);
      rd_reg(8'hF6, 16'h005F);
      chk("algo", alg, 1'b0);
      rd_reg(8'hF8, 16'h24A0);
      wr_reg(8'hF8, 16'hFFFF);
      rd_reg(8'hF8, 16'hA4A0);
      wr_reg(8'hFA, 16'hFFFF);
      rd_reg(8'hFA, 16'h0000);
      rd_reg(8'hFF, 16'h0000);
      rd_reg(8'h10, 16'h0000);
      rd_reg(8'hE4, 16'h2020);
      rd_reg(8'hEC, 16'h05E1);
      wr_reg(8'hEC, 16'h0400);
      rd_reg(8'hF6, 16'h0050);
      rd_reg(8'hEE, 16'h0001);
      rd_reg(8'hE6, 16'h0004);
   endtask
   // Main sequence
   initial begin
      resetn = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 16'h0000;
      ind_n = 4'h5; link_up = 1'b0; pol = 1'b0;
      err_total = 0; samples_checked = 0;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      t_reset();
      t_ctl();
      t_link();
      t_mirror();
      print_verdict();
   end
endmodule // pcsr_regs_bench
`default_nettype wire
